// File: rtl/soi_pkg.sv
package soi_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RES_MIN_MS = 120;
  localparam int unsigned RES_MAX_MS = 4000;
  localparam int unsigned FB_TIMEOUT_MS = 500;
  localparam int unsigned RES_MIN_CYC = (CLK_HZ / 1000) * RES_MIN_MS;
  localparam int unsigned RES_MAX_CYC = (CLK_HZ / 1000) * RES_MAX_MS;
  localparam int unsigned FB_CYC = (CLK_HZ / 1000) * FB_TIMEOUT_MS;
  localparam int unsigned CONTOUR_TOL_MM = 200;
  localparam int unsigned CNT_W = 28;
  localparam int unsigned MM_W = 16;

  typedef enum logic [1:0] {
    SOI_MODE_AUTO = 2'h0,
    SOI_MODE_START = 2'h1,
    SOI_MODE_START_RESTART = 2'h2
  } soi_mode_t;

  typedef enum logic [2:0] {
    SOI_ST_LOCKED = 3'h0,
    SOI_ST_WAIT_CLEAR = 3'h5,
    SOI_ST_ON_CHECK = 3'h1,
    SOI_ST_ON = 3'h3,
    SOI_ST_OFF_CHECK = 3'h2,
    SOI_ST_FAULT = 3'h6
  } soi_state_t;

  typedef struct packed {
    logic [MM_W-1:0] measured_mm;
    logic [MM_W-1:0] reference_mm;
    logic valid;
    logic enabled;
  } soi_contour_t;

  typedef struct packed {
    logic fault;
    logic contour_fault;
    logic feedback_fault;
    logic interlocked;
  } soi_status_t;
endpackage : soi_pkg

// File: rtl/soi_interlock.sv
`timescale 1ns/1ps
// Operation
// R1: Field violation switches primary outputs off
// R2: Start interlock holds off after power-up
// R3: Restart interlock holds off after violation
// R4: Restart interlock implies start interlock
// R5: Automatic mode releases when field clears
// R6: Reset press valid between 0.12 and 4 s
// R7: Compare contour against reference continuously
// R8: Contour deviation over 200 mm switches off
// R9: Optional dynamic contactor feedback monitoring
// R10: Feedback closed required before switch-on
// R11: Feedback must open within 500 ms after on
// R12: Feedback must close within 500 ms after off
// R13: Feedback timing failure latches fault state
// R14: Contactors assert feedback while outputs off
// R15: External control selects field pair
// R16: Start-up mode static, same all pairs
// R17: Fault persists until acknowledge or power cycle
module soi_interlock #(
  parameter int unsigned RES_MIN_CYC = soi_pkg::RES_MIN_CYC,
  parameter int unsigned RES_MAX_CYC = soi_pkg::RES_MAX_CYC,
  parameter int unsigned FB_CYC = soi_pkg::FB_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire soi_pkg::soi_mode_t mode_i,
  input wire logic feedback_enable_i,
  input wire logic field_violated_i,
  input wire logic reset_button_i,
  input wire logic contactor_feedback_input_i,
  input wire soi_pkg::soi_contour_t contour_i,
  input wire logic fault_ack_i,
  output logic primary_safety_outputs_o,
  output soi_pkg::soi_status_t status_o
);
  localparam logic [soi_pkg::CNT_W-1:0] RMIN = RES_MIN_CYC[soi_pkg::CNT_W-1:0];
  localparam logic [soi_pkg::CNT_W-1:0] RMAX = RES_MAX_CYC[soi_pkg::CNT_W-1:0];
  localparam logic [soi_pkg::CNT_W-1:0] FBT = FB_CYC[soi_pkg::CNT_W-1:0];
  localparam logic [soi_pkg::MM_W-1:0] TOL =
    soi_pkg::CONTOUR_TOL_MM[soi_pkg::MM_W-1:0];

  soi_pkg::soi_state_t state_reg, state_next;
  soi_pkg::soi_mode_t mode_reg;
  logic [soi_pkg::CNT_W-1:0] press_cnt_reg, press_cnt_next;
  logic [soi_pkg::CNT_W-1:0] fb_cnt_reg, fb_cnt_next;
  logic button_prev_reg;
  logic out_reg, out_next;
  logic contour_fault_reg;
  logic feedback_fault_reg, feedback_fault_next;
  logic captured_reg;
  logic fault_reg;
  logic interlocked_reg;

  wire logic [soi_pkg::MM_W-1:0] diff_mm;
  wire logic contour_bad;
  wire logic unsafe;
  wire logic release_press;
  wire logic interlock_on;
  wire logic restart_lock;
  wire logic fb_closed;
  wire logic fb_ok_for_on;
  wire logic fb_expired;
  wire soi_pkg::soi_state_t state_upd;

  // Contour compare
  assign diff_mm = (contour_i.measured_mm > contour_i.reference_mm) ?
    (contour_i.measured_mm - contour_i.reference_mm) :
    (contour_i.reference_mm - contour_i.measured_mm); // [R7]
  assign contour_bad = contour_i.enabled && contour_i.valid &&
    (diff_mm > TOL); // [R8]
  assign unsafe = field_violated_i || contour_bad ||
    contour_fault_reg; // [R1] [R8]
  // Button released after a valid hold
  assign release_press = button_prev_reg && !reset_button_i &&
    (press_cnt_reg >= RMIN) && (press_cnt_reg <= RMAX); // [R6]
  assign interlock_on = (mode_reg != soi_pkg::SOI_MODE_AUTO); // [R2] [R4]
  assign restart_lock =
    (mode_reg == soi_pkg::SOI_MODE_START_RESTART); // [R3]
  assign fb_closed = contactor_feedback_input_i; // [R14]
  assign fb_ok_for_on = !feedback_enable_i || fb_closed; // [R9] [R10]
  assign fb_expired = (fb_cnt_reg >= FBT); // [R11] [R12]
  // Auto mode leaves the locked state at once
  assign state_upd = (state_reg == soi_pkg::SOI_ST_LOCKED && !interlock_on) ?
    soi_pkg::SOI_ST_WAIT_CLEAR : state_next; // [R5] [R2]

  // Press duration counter, saturating
  always_comb begin
    press_cnt_next = press_cnt_reg;
    if (!reset_button_i) begin
      press_cnt_next = '0;
    end else if (press_cnt_reg <= RMAX) begin
      press_cnt_next = press_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    out_next = 1'b0;
    fb_cnt_next = '0;
    feedback_fault_next = feedback_fault_reg;
    case (state_reg)
      soi_pkg::SOI_ST_LOCKED: begin
        if (release_press && !unsafe && fb_ok_for_on) begin // [R2] [R10]
          state_next = feedback_enable_i ? soi_pkg::SOI_ST_ON_CHECK :
            soi_pkg::SOI_ST_ON;
          out_next = 1'b1;
        end
      end
      soi_pkg::SOI_ST_WAIT_CLEAR: begin
        if (!unsafe && fb_ok_for_on) begin // [R5] [R10]
          state_next = feedback_enable_i ? soi_pkg::SOI_ST_ON_CHECK :
            soi_pkg::SOI_ST_ON;
          out_next = 1'b1;
        end
      end
      soi_pkg::SOI_ST_ON_CHECK: begin
        out_next = 1'b1;
        fb_cnt_next = fb_cnt_reg + 1'b1;
        if (unsafe) begin // [R1]
          out_next = 1'b0;
          state_next = soi_pkg::SOI_ST_OFF_CHECK;
          fb_cnt_next = '0;
        end else if (!fb_closed) begin // [R11]
          state_next = soi_pkg::SOI_ST_ON;
        end else if (fb_expired) begin // [R13]
          out_next = 1'b0;
          feedback_fault_next = 1'b1;
          state_next = soi_pkg::SOI_ST_FAULT;
        end
      end
      soi_pkg::SOI_ST_ON: begin
        out_next = 1'b1;
        if (unsafe) begin // [R1]
          out_next = 1'b0;
          if (feedback_enable_i) begin // [R9]
            state_next = soi_pkg::SOI_ST_OFF_CHECK;
          end else if (restart_lock) begin // [R3]
            state_next = soi_pkg::SOI_ST_LOCKED;
          end else begin
            state_next = soi_pkg::SOI_ST_WAIT_CLEAR; // [R5]
          end
        end
      end
      soi_pkg::SOI_ST_OFF_CHECK: begin
        fb_cnt_next = fb_cnt_reg + 1'b1;
        if (fb_closed) begin // [R12]
          fb_cnt_next = '0;
          state_next = restart_lock ? soi_pkg::SOI_ST_LOCKED :
            soi_pkg::SOI_ST_WAIT_CLEAR; // [R3] [R5]
        end else if (fb_expired) begin // [R13]
          feedback_fault_next = 1'b1;
          state_next = soi_pkg::SOI_ST_FAULT;
        end
      end
      soi_pkg::SOI_ST_FAULT: begin
        if (fault_ack_i) begin // [R17]
          feedback_fault_next = 1'b0;
          state_next = interlock_on ? soi_pkg::SOI_ST_LOCKED :
            soi_pkg::SOI_ST_WAIT_CLEAR;
        end
      end
      default: begin
        state_next = soi_pkg::SOI_ST_FAULT;
      end
    endcase
  end

  // Mode sampled once after reset release
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      captured_reg <= 1'b0;
      mode_reg <= soi_pkg::SOI_MODE_START_RESTART;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      mode_reg <= mode_i; // [R16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= soi_pkg::SOI_ST_LOCKED;
      out_reg <= 1'b0;
      press_cnt_reg <= '0;
      fb_cnt_reg <= '0;
      button_prev_reg <= 1'b0;
      feedback_fault_reg <= 1'b0;
      fault_reg <= 1'b0;
      interlocked_reg <= 1'b1;
    end else if (!captured_reg) begin
      state_reg <= soi_pkg::SOI_ST_LOCKED;
      out_reg <= 1'b0;
      button_prev_reg <= reset_button_i;
      fault_reg <= 1'b0;
      interlocked_reg <= 1'b1;
    end else begin
      state_reg <= state_upd;
      fault_reg <= (state_upd == soi_pkg::SOI_ST_FAULT);
      interlocked_reg <= (state_upd == soi_pkg::SOI_ST_LOCKED);
      out_reg <= out_next;
      press_cnt_reg <= press_cnt_next;
      fb_cnt_reg <= fb_cnt_next;
      button_prev_reg <= reset_button_i;
      feedback_fault_reg <= feedback_fault_next;
    end
  end

  // Contour fault latches until acknowledge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      contour_fault_reg <= 1'b0;
    end else if (contour_bad) begin
      contour_fault_reg <= 1'b1; // [R8]
    end else if (fault_ack_i) begin
      contour_fault_reg <= 1'b0;
    end
  end

  assign primary_safety_outputs_o = out_reg;
  assign status_o.fault = fault_reg;
  assign status_o.contour_fault = contour_fault_reg;
  assign status_o.feedback_fault = feedback_fault_reg;
  assign status_o.interlocked = interlocked_reg;
endmodule : soi_interlock

// File: verification/soi_interlock_assertions.sv
`timescale 1ns/1ps
module soi_interlock_assertions #(
  parameter int unsigned FB_CYC = soi_pkg::FB_CYC
) (
  input logic clk_i,
  input logic resetn_i,
  input logic feedback_enable_i,
  input logic field_violated_i,
  input logic contactor_feedback_input_i,
  input soi_pkg::soi_contour_t contour_i,
  input logic fault_ack_i,
  input logic primary_safety_outputs_o,
  input soi_pkg::soi_status_t status_o
);
  logic on, fb, mon;
  int on_cnt, off_cnt, dm;
  assign on = primary_safety_outputs_o;
  assign fb = contactor_feedback_input_i;
  assign mon = feedback_enable_i && !status_o.fault;
  assign dm = int'(contour_i.measured_mm) - int'(contour_i.reference_mm);
  // Cycles spent with the feedback loop in the wrong state
  always_ff @(posedge clk_i) begin
    on_cnt <= (resetn_i && mon && on && fb) ? on_cnt + 1 : 0;
    off_cnt <= (resetn_i && mon && !on && !fb) ? off_cnt + 1 : 0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_violation_off: assert property (
    field_violated_i |=> !on) else $error("on after violation");
  a_contour_off: assert property (
    contour_i.enabled && contour_i.valid &&
    (dm > int'(soi_pkg::CONTOUR_TOL_MM) || -dm > int'(soi_pkg::CONTOUR_TOL_MM))
    |=> !on) else $error("on after contour deviation");
  a_fault_off: assert property (
    status_o.fault |=> !on) else $error("on in fault");
  a_fault_hold: assert property (
    status_o.fault && !fault_ack_i |=> status_o.fault)
    else $error("fault cleared without ack");
  a_rise_closed: assert property (
    $rose(on) && feedback_enable_i |-> $past(fb))
    else $error("release with open loop");
  a_rise_clear: assert property (
    $rose(on) |-> !$past(field_violated_i)) else $error("release in field");
  a_open_time: assert property (
    on_cnt <= FB_CYC + 3) else $error("loop open timeout missed");
  a_close_time: assert property (
    off_cnt <= FB_CYC + 3) else $error("loop close timeout missed");
endmodule : soi_interlock_assertions
bind soi_interlock soi_interlock_assertions #(.FB_CYC(FB_CYC)) u_sva (.*);

// File: verification/soi_contactor.sv
`timescale 1ns/1ps
module soi_contactor #(
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic on_i,
  input wire logic stuck_i,
  output logic fb_o
);
  int cnt = 0;
  initial fb_o = 1'b1;
  // Loop follows inverted outputs DLY+1 cycles after a change unless welded
  always @(posedge clk_i) begin
    if (stuck_i || fb_o == !on_i) cnt <= 0;
    else if (cnt < DLY) cnt <= cnt + 1;
    else fb_o <= !on_i;
  end
endmodule : soi_contactor

// File: verification/soi_interlock_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module soi_interlock_tb;
  // Violation of the field pair chosen by the safety control
  logic clk = 0, rn = 0, fen = 1, viol = 0, btn = 0, ack = 0;
  logic stuck = 0, fb, out;
  soi_pkg::soi_mode_t mode = soi_pkg::SOI_MODE_AUTO;
  soi_pkg::soi_contour_t ctr = {16'h03e8, 16'h03e8, 1'b1, 1'b1};
  soi_pkg::soi_status_t st;
  int bad_count = 0, total_checks = 0, cyc = 0;
  soi_interlock #(.RES_MIN_CYC(10), .RES_MAX_CYC(100), .FB_CYC(50)) dut (
    .clk_i(clk), .resetn_i(rn), .mode_i(mode), .feedback_enable_i(fen),
    .field_violated_i(viol), .reset_button_i(btn),
    .contactor_feedback_input_i(fb), .contour_i(ctr), .fault_ack_i(ack),
    .primary_safety_outputs_o(out), .status_o(st));
  soi_contactor #(.DLY(3)) u_ctr (.clk_i(clk), .on_i(out),
    .stuck_i(stuck), .fb_o(fb));
  initial forever #12.5 clk = ~clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic w(int n); repeat (n) @(negedge clk); endtask : w
  task automatic rst(soi_pkg::soi_mode_t m);
    rn = 0; mode = m; w(20); rn = 1; w(5);
  endtask : rst
  task automatic press(int n); btn = 1; w(n); btn = 0; w(3); endtask : press
  task automatic pulse_ack(); ack = 1; w(1); ack = 0; w(2); endtask : pulse_ack
  initial begin
    rst(soi_pkg::SOI_MODE_START_RESTART);
    `CHK("out", 1'b0, out)
    `CHK("lock", 1'b1, st.interlocked)
    press(5); `CHK("out", 1'b0, out)
    press(150); `CHK("out", 1'b0, out)
    press(20); `CHK("out", 1'b1, out)
    w(10); `CHK("fbf", 1'b0, st.feedback_fault)
    viol = 1; w(2); `CHK("out", 1'b0, out)
    viol = 0; w(10); `CHK("out", 1'b0, out)
    press(20); ctr.reference_mm = 16'h04b0; w(3);
    `CHK("out", 1'b1, out)
    ctr.reference_mm = 16'h04b1; w(2); `CHK("out", 1'b0, out)
    `CHK("cf", 1'b1, st.contour_fault)
    ctr.reference_mm = 16'h03e8; pulse_ack(); w(10);
    stuck = 1; press(20); w(60);
    `CHK("fbf", 1'b1, st.feedback_fault)
    `CHK("out", 1'b0, out)
    `CHK("flt", 1'b1, st.fault)
    stuck = 0; press(20); `CHK("out", 1'b0, out)
    pulse_ack(); press(20); `CHK("out", 1'b1, out)
    `CHK("flt", 1'b0, st.fault)
    w(5); viol = 1; stuck = 1; w(2); viol = 0; press(20);
    `CHK("out", 1'b0, out)
    w(60); `CHK("fbf", 1'b1, st.feedback_fault)
    pulse_ack(); press(20); `CHK("out", 1'b0, out)
    stuck = 0; rst(soi_pkg::SOI_MODE_AUTO); `CHK("out", 1'b1, out)
    viol = 1; w(2); `CHK("out", 1'b0, out)
    viol = 0; w(10); `CHK("out", 1'b1, out)
    rst(soi_pkg::SOI_MODE_START); `CHK("out", 1'b0, out)
    press(20); viol = 1; w(2); viol = 0; w(10);
    `CHK("out", 1'b1, out)
    fen = 0; stuck = 1; viol = 1; w(2); viol = 0; w(60);
    `CHK("fbf", 1'b0, st.feedback_fault)
    `CHK("out", 1'b1, out)
    end_of_test();
  end
endmodule : soi_interlock_tb
